// ### logic/ohc_regs.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef OHC_REGS_SVH
`define OHC_REGS_SVH
`define OHC_ADDR_FET_DRV   8'h12
`define OHC_ADDR_FET_PRES  8'h1E
`define OHC_FET_DRV_RST    8'h00
`define OHC_BIT_DRV_DIS    7
`define OHC_BIT_DRV_EN1    0
`define OHC_BIT_DRV_EN2    1
`define OHC_BIT_PAIR1      6
`define OHC_BIT_PAIR2      7
`define OHC_SRC_OTG        4'h7
`define OHC_FAIL_LIMIT     3'h7
`define OHC_CLK_NS         10
`define OHC_OTG_DLY_NS     10000000
`define OHC_OTG_DLY_CYC    (`OHC_OTG_DLY_NS / `OHC_CLK_NS)
`define OHC_OOA_KHZ        20
`define OHC_OOA_NS         (1000000 / `OHC_OOA_KHZ)
`define OHC_OOA_CYC        (`OHC_OOA_NS / `OHC_CLK_NS)
`define OHC_VOUT_MIN_MV    16'h0AF0
`define OHC_VOUT_MAX_MV    16'h55F0
`define OHC_VOUT_STEP_MV   16'h000A
`define OHC_ILIM_MIN_MA    12'h078
`define OHC_ILIM_MAX_MA    12'hCF8
`define OHC_ILIM_STEP_MA   12'h028
`define OHC_SENSE_NA_MA    21'h000019
`define OHC_INT_PULSE_CYC  8'h64
`endif

// ### logic/ohc_pkg.sv
// Types shared by the mode-control block and its helpers.
package ohc_pkg;
  // Synchronised analog and pin status inputs.
  typedef struct packed {
    logic bus_valid;
    logic bat_valid;
    logic bat_otg_ok;
    logic bus_present;
    logic ts_ok;
    logic light_load;
    logic bat_low;
    logic bat_present;
    logic dischg_over;
    logic iout_zero;
    logic pair1;
    logic pair2;
    logic ship_present;
    logic big_dischg;
  } ohc_pins_t;
  // Reverse-boost sequencing states.
  typedef enum logic [2:0] {
    OTG_OFF    = 3'b000,
    OTG_DELAY  = 3'b001,
    OTG_BUS_ON = 3'b010,
    OTG_PARK   = 3'b011,
    OTG_FET_ON = 3'b100
  } ohc_otg_st_t;
  // Decoded reverse-boost targets.
  typedef struct packed {
    logic [15:0] vout_mv;
    logic [11:0] ilim_ma;
  } ohc_otg_set_t;
endpackage

// ### logic/ohc_timer.sv
// Up-counter that runs while enabled and flags when a limit is reached.
`timescale 1ns/100ps
module ohc_timer (
  input  wire logic        sys_clk_in, // System clock.
  input  wire logic        rstn_in,    // Asynchronous reset, active low.
  input  wire logic        run_in,     // Count while high, clear when low.
  input  wire logic [19:0] lim_in,     // Count at which done rises.
  output logic             done_out    // High while the limit is reached.
);
  import ohc_pkg::*;
  logic [19:0] cnt_q; // Elapsed cycles.
  logic [19:0] cnt_d; // Next count.

  // Counting saturates at the limit so done stays up until run drops.
  always_comb begin
    if (!run_in) begin
      cnt_d = 20'h00000;
    end else if (cnt_q != lim_in) begin
      cnt_d = cnt_q + 20'h00001;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // Count register.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 20'h00000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_out = run_in && (cnt_q == lim_in);
endmodule

// ### logic/ohc_fail_cnt.sv
// Counter of consecutive failures that trips at a fixed limit.
`timescale 1ns/100ps
`include "ohc_regs.svh"
module ohc_fail_cnt (
  input  wire logic sys_clk_in, // System clock.
  input  wire logic rstn_in,    // Asynchronous reset, active low.
  input  wire logic fail_in,    // One-cycle pulse per failed attempt.
  input  wire logic pass_in,    // One-cycle pulse per good attempt.
  output logic      trip_out    // One-cycle pulse at the limit.
);
  import ohc_pkg::*;
  logic [2:0] cnt_q; // Failures in a row.
  logic [2:0] cnt_d; // Next count.
  logic       hit;   // This failure reaches the limit.

  // A pass breaks the run; the count restarts after a trip.
  always_comb begin
    hit = fail_in && (cnt_q == (`OHC_FAIL_LIMIT - 3'h1));
    if (pass_in || hit) begin
      cnt_d = 3'h0;
    end else if (fail_in) begin
      cnt_d = cnt_q + 3'h1;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // Count register.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign trip_out = hit && !pass_in;
endmodule

// ### logic/ohc_mode_ctrl.sv
// Light-load, high-impedance and reverse-boost mode control.
// Function
// - Forward light load pulse-skips with charge off or battery low, unless disabled.
// - Out-of-audio keeps switching above 20 kHz.
// - High-impedance stops switching and regulator.
// - Seven consecutive failures force high-impedance.
// - Current sense enables only with valid supply.
// - Sense reports discharge only in boost/battery.
// - Boost voltage 2.8-22 V, 10 mV steps.
// - Boost current limit 120 mA-3.32 A.
// - Boost enables only under battery, bus, thermal.
// - Source status reads 0111 in boost.
// - Without FET pairs, bus rises after 10 ms.
// - With FET pairs, output waits drive enable.
// - Boost pulse-skips unless its disable set.
// - Over-threshold discharge reduces current, sets bits.
// - Regulation event pulses interrupt when unmasked.
// - Zero output current releases discharge limiting.
// - Ship FET and enable arm over-current trip.
// - Interrupt is a low-going pulse.
`timescale 1ns/100ps
`include "ohc_regs.svh"
module ohc_mode_ctrl #(
  parameter logic [19:0] OTG_DLY_CYC = 20'(`OHC_OTG_DLY_CYC), // 10 ms.
  parameter logic [19:0] OOA_CYC     = 20'(`OHC_OOA_CYC)      // 50 us.
) (
  input  wire logic           sys_clk_in,     // System clock, 100 MHz.
  input  wire logic           rstn_in,        // Async reset, active low.
  input  wire logic [7:0]     reg_addr_in,    // Register address.
  input  wire logic           reg_wr_in,      // Register write strobe.
  input  wire logic [7:0]     reg_wdata_in,   // Register write data.
  output logic [7:0]          reg_rdata_out,  // Register read data.
  input  wire ohc_pkg::ohc_pins_t pins_in,    // Asynchronous status.
  input  wire logic           chg_en_in,      // Charging enabled.
  input  wire logic           charging_in,    // Current flows into battery.
  input  wire logic           fwd_pfm_dis_in, // Forward pulse-skip off.
  input  wire logic           forward_out_of_audio_disable_in, // Forward out-of-audio off.
  input  wire logic           rev_pfm_dis_in, // Boost pulse-skip off.
  input  wire logic           rev_ooa_dis_in, // Boost out-of-audio off.
  input  wire logic           sw_pulse_in,    // Converter switched.
  input  wire logic           hiz_wr_in,      // Host writes hiz bit.
  input  wire logic           hiz_wdata_in,   // Value written.
  input  wire logic           poor_fail_in,   // Qualification failed.
  input  wire logic           poor_pass_in,   // Qualification passed.
  input  wire logic           short_fail_in,  // System short attempt.
  input  wire logic           short_pass_in,  // System short cleared.
  input  wire logic           sense_en_in,    // Current sense enable bit.
  input  wire logic [15:0]    bat_ma_in,      // Battery current, mA.
  input  wire logic           otg_en_in,      // Reverse-boost enable bit.
  input  wire logic [10:0]    vset_in,        // Boost voltage code.
  input  wire logic [6:0]     iset_in,        // Boost current code.
  input  wire logic [1:0]     dis_thr_in,     // Discharge threshold code.
  input  wire logic           dreg_mask_in,   // Regulation mask bit.
  input  wire logic           flag_rd_in,     // Host reads the flag.
  input  wire logic           batoc_en_in,    // Over-current enable bit.
  input  wire logic [3:0]     src_stat_in,    // Detected source status.
  output logic                hiz_out,        // High-impedance bit.
  output logic                switch_en_out,  // Converter may switch.
  output logic                regulator_out,  // Internal regulator on.
  output logic                bat_sw_out,     // Battery switch forced on.
  output logic                pfm_out,        // Pulse-skip selected.
  output logic                ooa_out,        // Out-of-audio active.
  output logic                sw_force_out,   // Forced switching pulse.
  output logic                sense_on_out,   // Current sense active.
  output logic [20:0]         sense_na_out,   // Sense output, nA.
  output logic                otg_mode_out,   // Reverse-boost mode.
  output logic                bus_rise_out,   // Bus output ramps.
  output logic                fet1_drv_out,   // First-input FETs on.
  output logic                fet2_drv_out,   // Second-input FETs on.
  output ohc_pkg::ohc_otg_set_t otg_set_out,  // Boost targets.
  output logic [3:0]          src_stat_out,   // Source status field.
  output logic [1:0]          dis_thr_out,    // Active threshold code.
  output logic                iout_red_out,   // Reduce boost current.
  output logic                dreg_stat_out,  // Regulation status.
  output logic                dreg_flag_out,  // Regulation flag.
  output logic                int_n_out,      // Interrupt, active low.
  output logic                ocp_arm_out,    // Over-current armed.
  output logic                ocp_trip_out    // Over-current tripped.
);
  import ohc_pkg::*;

  ohc_pins_t   meta_q;             // First synchroniser stage.
  ohc_pins_t   pin_q;              // Second stage, safe to read.
  logic [7:0]  drv_q, drv_d;       // Input FET drive register.
  logic [7:0]  rdata_q, rdata_d;   // Registered read data.
  logic        hiz_q, hiz_d;       // High-impedance bit.
  ohc_otg_st_t st_q, st_d;         // Reverse-boost state.
  logic        fet1_q, fet1_d;     // First pair driven.
  logic        fet2_q, fet2_d;     // Second pair driven.
  ohc_otg_set_t set_q, set_d;      // Decoded targets.
  logic [20:0] sense_q, sense_d;   // Sense output.
  logic        flag_q, flag_d;     // Sticky regulation flag.
  logic        dreg_q, dreg_d;     // Live regulation state.
  logic [7:0]  int_q, int_d;       // Interrupt pulse counter.
  logic        poor_trip;          // Poor-source failures hit limit.
  logic        short_trip;         // Short failures hit limit.
  logic        dly_done;           // Boost start delay elapsed.
  logic        ooa_done;           // Silence reached its limit.
  logic        keep;               // Boost may stay on.
  logic        allow;              // Boost may start.
  logic        direct;             // No FET pairs in the path.
  logic        want1, want2;       // Drive enable with pair present.
  logic        fwd_pfm, rev_pfm;   // Pulse-skip per direction.
  logic [12:0] ilim_raw;           // Unclamped current target.
  logic        ooa_seen_q;         // Forced pulse was just sent.

  // Two-flop synchroniser; only the second stage feeds logic.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      pin_q  <= '0;
    end else begin
      meta_q <= pins_in;
      pin_q  <= meta_q;
    end
  end

  // Failure counters; each good attempt restarts its run.
  ohc_fail_cnt u_poor (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .fail_in    (poor_fail_in),
    .pass_in    (poor_pass_in),
    .trip_out   (poor_trip)
  );
  ohc_fail_cnt u_short (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .fail_in    (short_fail_in),
    .pass_in    (short_pass_in),
    .trip_out   (short_trip)
  );

  // Register file and high-impedance bit.
  always_comb begin
    drv_d = drv_q;
    if (reg_wr_in && (reg_addr_in == `OHC_ADDR_FET_DRV)) begin
      drv_d = reg_wdata_in;
    end
    // A trip wins over a host clear in the same cycle.
    if (poor_trip || short_trip) begin
      hiz_d = 1'b1;
    end else if (hiz_wr_in) begin
      hiz_d = hiz_wdata_in;
    end else begin
      hiz_d = hiz_q;
    end
    // Unmapped addresses read zero; presence bits are live.
    rdata_d = 8'h00;
    if (reg_addr_in == `OHC_ADDR_FET_DRV) begin
      rdata_d = drv_q;
    end else if (reg_addr_in == `OHC_ADDR_FET_PRES) begin
      rdata_d[`OHC_BIT_PAIR1] = pin_q.pair1;
      rdata_d[`OHC_BIT_PAIR2] = pin_q.pair2;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drv_q   <= `OHC_FET_DRV_RST;
      hiz_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      drv_q   <= drv_d;
      hiz_q   <= hiz_d;
      rdata_q <= rdata_d;
    end
  end

  // Boost start delay when the bus is driven straight.
  ohc_timer u_dly (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .run_in     (st_q == OTG_DELAY),
    .lim_in     (OTG_DLY_CYC),
    .done_out   (dly_done)
  );

  // Reverse-boost sequencing.
  always_comb begin
    keep   = otg_en_in && pin_q.bat_otg_ok;
    allow  = keep && !pin_q.bus_present && pin_q.ts_ok;
    direct = drv_q[`OHC_BIT_DRV_DIS] || !(pin_q.pair1 || pin_q.pair2);
    want1  = drv_q[`OHC_BIT_DRV_EN1] && pin_q.pair1;
    want2  = drv_q[`OHC_BIT_DRV_EN2] && pin_q.pair2;
    st_d   = st_q;
    unique case (st_q)
      OTG_OFF: begin
        if (allow) begin
          st_d = direct ? OTG_DELAY : OTG_PARK;
        end
      end
      OTG_DELAY: begin
        if (!keep) begin
          st_d = OTG_OFF;
        end else if (dly_done) begin
          st_d = OTG_BUS_ON;
        end
      end
      OTG_BUS_ON: begin
        if (!keep) begin
          st_d = OTG_OFF;
        end
      end
      OTG_PARK: begin
        if (!keep) begin
          st_d = OTG_OFF;
        end else if (want1 || want2) begin
          st_d = OTG_FET_ON;
        end
      end
      OTG_FET_ON: begin
        if (!keep) begin
          st_d = OTG_OFF;
        end else if (!fet1_q && !fet2_q && !want1 && !want2) begin
          st_d = OTG_PARK;
        end
      end
      default: begin
        st_d = OTG_OFF;
      end
    endcase
    // One pair at a time: the other must be released first.
    fet1_d = (st_d == OTG_FET_ON) && want1 && !fet2_q;
    fet2_d = (st_d == OTG_FET_ON) && want2 && !fet1_q &&
             !(want1 && !fet1_q && !fet2_q);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q   <= OTG_OFF;
      fet1_q <= 1'b0;
      fet2_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      fet1_q <= fet1_d;
      fet2_q <= fet2_d;
    end
  end

  // Target decode, clamped to the documented span.
  always_comb begin
    set_d.vout_mv = `OHC_VOUT_MIN_MV + 16'(vset_in) * `OHC_VOUT_STEP_MV;
    if (set_d.vout_mv > `OHC_VOUT_MAX_MV) begin
      set_d.vout_mv = `OHC_VOUT_MAX_MV;
    end
    // Top codes overflow 12 bits, so the sum is formed one bit wider.
    ilim_raw = 13'(`OHC_ILIM_MIN_MA) + 13'(iset_in) * 13'(`OHC_ILIM_STEP_MA);
    if (ilim_raw > 13'(`OHC_ILIM_MAX_MA)) begin
      set_d.ilim_ma = `OHC_ILIM_MAX_MA;
    end else begin
      set_d.ilim_ma = ilim_raw[11:0];
    end
    // Current sense: no discharge reading while supplementing.
    if (sense_on_out && (charging_in || otg_mode_out ||
                         !pin_q.bus_valid)) begin
      sense_d = 21'(bat_ma_in) * `OHC_SENSE_NA_MA;
    end else begin
      sense_d = 21'h000000;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      set_q   <= '0;
      sense_q <= 21'h000000;
    end else begin
      set_q   <= set_d;
      sense_q <= sense_d;
    end
  end

  // Discharge regulation; releases once output current is zero.
  always_comb begin
    dreg_d = otg_mode_out && pin_q.dischg_over &&
             !pin_q.iout_zero;
    // Set wins over the read that clears it.
    flag_d = (dreg_d && !dreg_q) || (flag_q && !flag_rd_in);
    if (dreg_d && !dreg_q && !dreg_mask_in) begin
      int_d = `OHC_INT_PULSE_CYC;
    end else if (int_q != 8'h00) begin
      int_d = int_q - 8'h01;
    end else begin
      int_d = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dreg_q <= 1'b0;
      flag_q <= 1'b0;
      int_q  <= 8'h00;
      ooa_seen_q <= 1'b0;
    end else begin
      ooa_seen_q <= ooa_done;
      dreg_q <= dreg_d;
      flag_q <= flag_d;
      int_q  <= int_d;
    end
  end

  // Silence watchdog: forces a pulse before the audible band.
  ohc_timer u_ooa (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .run_in     (ooa_out && !sw_pulse_in && !ooa_seen_q),
    .lim_in     (OOA_CYC - 20'h00002),
    .done_out   (ooa_done)
  );

  // Light-load mode selection for both directions.
  always_comb begin
    fwd_pfm = !otg_mode_out && (!chg_en_in || pin_q.bat_low) &&
              !fwd_pfm_dis_in;
    rev_pfm = otg_mode_out && !rev_pfm_dis_in;
    pfm_out = pin_q.light_load && (fwd_pfm || rev_pfm) && !hiz_q;
    ooa_out = pfm_out && !(otg_mode_out ? rev_ooa_dis_in
                                        : forward_out_of_audio_disable_in);
  end

  assign sw_force_out  = ooa_done;
  assign hiz_out       = hiz_q;
  assign switch_en_out = !hiz_q;
  assign regulator_out = !hiz_q;
  assign bat_sw_out    = hiz_q && pin_q.bat_present;
  assign sense_on_out  = sense_en_in &&
                         (pin_q.bus_valid || pin_q.bat_valid);
  assign sense_na_out  = sense_q;
  assign otg_mode_out  = (st_q != OTG_OFF);
  assign bus_rise_out  = (st_q == OTG_BUS_ON);
  assign fet1_drv_out  = fet1_q;
  assign fet2_drv_out  = fet2_q;
  assign otg_set_out   = set_q;
  assign src_stat_out  = otg_mode_out ? `OHC_SRC_OTG : src_stat_in;
  assign dis_thr_out   = dis_thr_in;
  assign iout_red_out  = dreg_q;
  assign dreg_stat_out = dreg_q;
  assign dreg_flag_out = flag_q;
  assign int_n_out     = (int_q == 8'h00);
  assign ocp_arm_out   = pin_q.ship_present && batoc_en_in;
  assign ocp_trip_out  = ocp_arm_out && pin_q.big_dischg;
  assign reg_rdata_out = rdata_q;

  // Checks on the block's own behaviour.
  hiz_trip_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (poor_trip || short_trip) |=> hiz_q)
    else $error("hiz bit not set after trip");
  bus_delay_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(bus_rise_out) |-> $past(st_q) == OTG_DELAY && $past(dly_done))
    else $error("bus rose without the start delay");
  src_otg_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    otg_mode_out |-> src_stat_out == 4'h7)
    else $error("source status wrong in boost");
  fet_one_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !(fet1_q && fet2_q))
    else $error("both FET pairs driven");
  int_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(dreg_q) && !$past(dreg_mask_in) |-> !int_n_out [*8])
    else $error("interrupt pulse missing");
  int_end_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $fell(int_n_out) |-> ##[99:101] int_n_out)
    else $error("interrupt held too long");
  flag_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    flag_q && !flag_rd_in |=> flag_q)
    else $error("flag lost before read");
  sense_sup_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !charging_in && !otg_mode_out && pin_q.bus_valid |=> sense_q == 0)
    else $error("sense reported in supplement");
  otg_start_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(otg_mode_out) |-> $past(allow))
    else $error("boost started without conditions");
  vout_cap_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    set_q.vout_mv <= 16'h55F0 && set_q.ilim_ma <= 12'hCF8)
    else $error("boost target out of range");
  hiz_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    hiz_q |-> !switch_en_out && !regulator_out && !pfm_out)
    else $error("switching while high-impedance");
endmodule

// ### tb/ohc_host_model.sv
// Host processor model that reaches the mode-control registers.
`timescale 1ns/100ps
`include "ohc_regs.svh"
module ohc_host_model (
  input  wire logic       sys_clk_in, // System clock.
  input  wire logic [7:0] rdata_in,   // Register read data.
  output logic [7:0]      addr_out,   // Register address.
  output logic            wr_out,     // Write strobe.
  output logic [7:0]      wdata_out   // Write data.
);
  logic [7:0] shadow_q; // Last value written to the drive control.
  int         slow;     // Idle cycles inserted before each write.
  initial begin
    {addr_out, wr_out, wdata_out} = '0;
    shadow_q = `OHC_FET_DRV_RST;
    slow     = 0;
  end
  // A write is launched just after an edge and taken at the next one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (slow) @(posedge sys_clk_in);
    #(slow > 0 ? 1 : 0);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(posedge sys_clk_in);
    #1;
    wr_out    = 1'b0;
    wdata_out = ~d; // Stale data is inverted so nothing relies on it.
    if (a == `OHC_ADDR_FET_DRV) shadow_q = d;
  endtask
  // The address is held two edges; data is taken after the second.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_out = a;
    repeat (2) @(posedge sys_clk_in);
    #1;
    d = rdata_in;
  endtask
  // Output moves break-before-make: the active pair is dropped first.
  task automatic move(input int from, input int to);
    wr(`OHC_ADDR_FET_DRV, shadow_q & ~(8'h01 << from));
    @(posedge sys_clk_in);
    #1;
    wr(`OHC_ADDR_FET_DRV, shadow_q | (8'h01 << to));
  endtask
endmodule

// ### tb/tb_ohc_mode_ctrl.sv
// Self-checking bench for light-load, high-impedance and boost control.
`timescale 1ns/100ps
`include "ohc_regs.svh"
module tb_ohc_mode_ctrl;
  import ohc_pkg::*;
  logic sys_clk_in, rstn_in, reg_wr_in, chg_en_in, charging_in;
  logic fwd_pfm_dis_in, forward_out_of_audio_disable_in, rev_pfm_dis_in, rev_ooa_dis_in;
  logic sw_pulse_in, hiz_wr_in, hiz_wdata_in, sense_en_in, otg_en_in;
  logic poor_fail_in, poor_pass_in, short_fail_in, short_pass_in;
  logic dreg_mask_in, flag_rd_in, batoc_en_in, hiz_out, switch_en_out;
  logic regulator_out, bat_sw_out, pfm_out, ooa_out, sw_force_out;
  logic sense_on_out, otg_mode_out, bus_rise_out, fet1_drv_out;
  logic fet2_drv_out, iout_red_out, dreg_stat_out, dreg_flag_out;
  logic int_n_out, ocp_arm_out, ocp_trip_out;
  logic [7:0]   reg_addr_in, reg_wdata_in, reg_rdata_out, r, w;
  logic [15:0]  bat_ma_in;
  logic [10:0]  vset_in;
  logic [6:0]   iset_in;
  logic [1:0]   dis_thr_in, dis_thr_out;
  logic [3:0]   src_stat_in, src_stat_out;
  logic [20:0]  sense_na_out;
  ohc_pins_t    pins_in;
  ohc_otg_set_t otg_set_out;
  int           fail_count, total_checks, k;
  wire  [2:0]   watch = {sw_force_out, ~int_n_out, bus_rise_out};
  // Counts are shortened so the run stays short.
  ohc_mode_ctrl #(.OTG_DLY_CYC(20'h00014), .OOA_CYC(20'h0000A)) DUT (.*);
  ohc_host_model HOST (.sys_clk_in, .rdata_in(reg_rdata_out),
    .addr_out(reg_addr_in), .wr_out(reg_wr_in), .wdata_out(reg_wdata_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Comparison of a seen value against the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for one watched output; running out ends the run.
  task automatic waitw(input int b, input int lim);
    int n;
    n = 0;
    while (watch[b] !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n == lim) begin
      chk(32'h0, 32'h1);
      final_report();
    end
  endtask
  // Boost targets clamp at the top of their documented span.
  function automatic logic [27:0] set_exp(input int v, input int i);
    set_exp = {16'(v > 1920 ? 22000 : 2800 + 10 * v),
               12'(i > 80 ? 3320 : 120 + 40 * i)};
  endfunction
  initial begin
    void'($urandom(32'hF1C40640));
    {chg_en_in, charging_in, fwd_pfm_dis_in, forward_out_of_audio_disable_in, sw_pulse_in,
     rev_pfm_dis_in, rev_ooa_dis_in, hiz_wr_in, hiz_wdata_in, poor_fail_in,
     poor_pass_in, short_fail_in, short_pass_in, sense_en_in, otg_en_in,
     dreg_mask_in, flag_rd_in, batoc_en_in, pins_in} = '0;
    {bat_ma_in, vset_in, iset_in, dis_thr_in, src_stat_in} = '0;
    fail_count = 0;
    total_checks = 0;
    rstn_in = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    rstn_in = 1'b1;
    cyc(1);
    // Reset values, read-only and unmapped places, read-back.
    HOST.rd(8'h12, r);
    chk(r, `OHC_FET_DRV_RST);
    chk({hiz_out, switch_en_out, int_n_out}, 3'b011);
    HOST.wr(8'h1E, 8'hFF);
    HOST.rd(8'h1E, r);
    chk(r, 8'h00);
    HOST.rd(8'h5A, r);
    chk(r, 8'h00);
    w = 8'($urandom) & 8'h83;
    HOST.slow = 2;
    HOST.wr(8'h12, w);
    HOST.rd(8'h12, r);
    chk(r, w);
    HOST.slow = 0;
    {dis_thr_in, src_stat_in} = 6'($urandom);
    cyc(2);
    chk({dis_thr_out, src_stat_out}, {dis_thr_in, src_stat_in});
    // Forward light load over every mix of the three controls.
    pins_in.light_load = 1'b1;
    for (k = 0; k < 8; k++) begin
      {fwd_pfm_dis_in, chg_en_in, pins_in.bat_low} = 3'(k);
      cyc(3);
      chk(pfm_out, !fwd_pfm_dis_in && (!chg_en_in || pins_in.bat_low));
      chk(ooa_out, !fwd_pfm_dis_in && (!chg_en_in || pins_in.bat_low));
    end
    fwd_pfm_dis_in = 1'b0;
    waitw(2, 12);
    forward_out_of_audio_disable_in = 1'b1;
    cyc(1);
    chk(ooa_out, 1'b0);
    // Host high impedance, then each failure kind trips it.
    pins_in.bat_present = 1'b1;
    for (k = 0; k < 3; k++) begin
      {hiz_wr_in, hiz_wdata_in} = {1'b1, k == 0};
      cyc(1);
      hiz_wr_in = 1'b0;
      cyc(3);
      if (k == 0) chk({hiz_out, switch_en_out, regulator_out, bat_sw_out},
                      4'b1001);
      else begin
        // Six failures, a pass, six more: the run never reaches seven.
        for (int j = 0; j < 13; j++) begin
          {short_fail_in, poor_fail_in} = j == 6 ? 2'b00 : 2'(k);
          {short_pass_in, poor_pass_in} = j == 6 ? 2'(k) : 2'b00;
          cyc(1);
        end
        {short_fail_in, poor_fail_in, short_pass_in, poor_pass_in} = '0;
        chk(hiz_out, 1'b0);
        {short_fail_in, poor_fail_in} = 2'(k);
        cyc(1);
        {short_fail_in, poor_fail_in} = 2'b00;
        cyc(2);
        chk(hiz_out, 1'b1);
      end
    end
    {hiz_wr_in, hiz_wdata_in} = 2'b10;
    cyc(1);
    hiz_wr_in = 1'b0;
    // Current sense: enable needs a valid supply, silent in supplement.
    sense_en_in = 1'b1;
    bat_ma_in = 16'($urandom % 5000);
    cyc(4);
    chk(sense_on_out, 1'b0);
    pins_in.bat_valid = 1'b1;
    cyc(4);
    chk({sense_on_out, sense_na_out}, {1'b1, 21'(25 * bat_ma_in)});
    pins_in.bus_valid = 1'b1;
    cyc(4);
    chk(sense_na_out, 21'h000000);
    // Direct boost: refused while the bus is present, then delayed.
    HOST.wr(8'h12, 8'h80);
    {pins_in.bat_otg_ok, pins_in.ts_ok, pins_in.bus_present} = 3'b111;
    otg_en_in = 1'b1;
    cyc(5);
    chk(otg_mode_out, 1'b0);
    pins_in.bus_present = 1'b0;
    cyc(4);
    chk({otg_mode_out, src_stat_out, bus_rise_out}, 6'h2E);
    waitw(0, 25);
    for (k = 0; k < 3; k++) begin
      {vset_in, iset_in} = k ? 18'($urandom) : 18'h3FFFF;
      cyc(2);
      chk(otg_set_out, set_exp(vset_in, iset_in));
    end
    chk({pfm_out, ooa_out}, 2'b11);
    {rev_pfm_dis_in, rev_ooa_dis_in} = 2'b01;
    cyc(1);
    chk({pfm_out, ooa_out}, 2'b10);
    rev_pfm_dis_in = 1'b1;
    cyc(1);
    chk(pfm_out, 1'b0);
    // Discharge regulation, flag, interrupt pulse and its mask.
    pins_in.dischg_over = 1'b1;
    waitw(1, 10);
    chk({dreg_stat_out, iout_red_out, dreg_flag_out}, 3'b111);
    cyc(90);
    chk(int_n_out, 1'b0);
    cyc(20);
    chk(int_n_out, 1'b1);
    pins_in.dischg_over = 1'b0;
    cyc(4);
    chk({dreg_stat_out, dreg_flag_out}, 2'b01);
    flag_rd_in = 1'b1;
    cyc(1);
    flag_rd_in = 1'b0;
    cyc(1);
    chk(dreg_flag_out, 1'b0);
    {dreg_mask_in, pins_in.dischg_over} = 2'b11;
    cyc(6);
    chk({dreg_stat_out, dreg_flag_out, int_n_out}, 3'b111);
    pins_in.iout_zero = 1'b1;
    cyc(4);
    chk(dreg_stat_out, 1'b0);
    {pins_in.ship_present, batoc_en_in, pins_in.big_dischg} = 3'b111;
    cyc(4);
    chk({ocp_arm_out, ocp_trip_out}, 2'b11);
    // Boost through the input FET pairs, then moved between inputs.
    otg_en_in = 1'b0;
    {pins_in.pair1, pins_in.pair2} = 2'b11;
    cyc(2);
    chk(otg_mode_out, 1'b0);
    HOST.wr(8'h12, 8'h00);
    otg_en_in = 1'b1;
    cyc(30);
    HOST.rd(8'h1E, r);
    chk(r, 8'hC0);
    chk({otg_mode_out, bus_rise_out, fet1_drv_out}, 3'b100);
    HOST.wr(8'h12, 8'h01);
    cyc(2);
    chk({fet1_drv_out, fet2_drv_out}, 2'b10);
    HOST.move(0, 1);
    cyc(2);
    chk({fet1_drv_out, fet2_drv_out}, 2'b01);
    final_report();
  end
endmodule
